// ===== inc/burst_sram_pkg.sv
// Purpose: Shared constants and types for the burst SRAM address sequencer
// Assumes: Open-drain straps, where an enable of 0 means the strap is grounded
// Notes:   An N.C. strap has its enable at 1, so the pin is left floating
package burst_sram_pkg;

   localparam int ADDR_W_DEF   = 16;            // External address width
   localparam int BURST_LO_W   = 2;             // Sequenced low address bits
   localparam int LANES        = 8;             // Byte lanes of the word
   localparam int LANE_W       = 9;             // Eight data bits plus parity
   localparam int WORD_W       = LANES * LANE_W;

   localparam logic [1:0] BEAT_RST  = 2'h0;     // First beat of a burst
   localparam logic [1:0] BEAT_STEP = 2'h1;     // Counter increment per advance

   // Strap drive enables, active low: 0 = grounded, 1 = N.C.
   localparam logic [1:0] SIZE_256KB_OE_N = 2'h1; // First open, second grounded
   localparam logic [1:0] SIZE_512KB_OE_N = 2'h0; // Both grounded
   localparam logic [1:0] SIZE_1MB_OE_N   = 2'h2; // First grounded, second open
   localparam logic       ORDER_INTL_OE_N = 1'h0; // Interleaved: grounded
   localparam logic       ORDER_LIN_OE_N  = 1'h1; // Linear or async: N.C.

   typedef enum {
      SIZE_256KB,
      SIZE_512KB,
      SIZE_1MB
   } module_size_t;

   typedef enum {
      ORDER_INTERLEAVED,
      ORDER_LINEAR,
      ORDER_ASYNC
   } burst_order_t;

   // One clock's worth of synchronous control pins
   typedef struct packed {
      logic             cpu_addr_strobe_n;
      logic             ctrl_addr_strobe_n;
      logic             burst_advance_n;
      logic             chip_enable_n;
      logic [LANES-1:0] byte_write_n;
   } bus_ctl_t;

endpackage

// ===== hw/burst_sram_address_sequencer.sv
// Purpose: Burst address sequencing, byte-lane writes and presence straps
// Assumes: All control pins but output enable are sampled on the module clock, setup met
// Notes:   Burst order and size are fixed per build by parameters
`timescale 1ns/10ps
module burst_sram_address_sequencer
   import burst_sram_pkg::*;
#(
   parameter int           ADDR_W      = ADDR_W_DEF,
   parameter burst_order_t BURST_ORDER = ORDER_INTERLEAVED,
   parameter module_size_t MODULE_SIZE = SIZE_512KB
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] ext_addr,
   input  wire bus_ctl_t          ctl,
   input  wire logic              output_enable_n,
   input  wire logic [WORD_W-1:0] data_in,
   output logic [WORD_W-1:0]      data_out,
   output logic                   data_oe_n,
   output logic [ADDR_W-1:0]      burst_addr,
   output logic [2:0]             id_strap_out,
   output logic [2:0]             id_strap_oe_n
);

   localparam int HI_W = ADDR_W - BURST_LO_W;

   wire [WORD_W-1:0]      rd_word;
   logic [HI_W-1:0]       hi_r;
   logic [BURST_LO_W-1:0] start_r;
   logic [BURST_LO_W-1:0] beat_r;
   logic [BURST_LO_W-1:0] beat_nxt;
   logic [BURST_LO_W-1:0] lo_r;
   logic [BURST_LO_W-1:0] lo_nxt;
   logic [WORD_W-1:0]     data_out_r;
   logic                  sel_r;
   logic                  cpu_take;
   logic                  ctrl_take;
   logic                  load;
   logic                  advance;
   logic                  wr_ok;
   logic [LANES-1:0]      lane_wr;
   logic [ADDR_W-1:0]     eff_addr;

   // Low address of a given beat in the build's burst order
   function automatic logic [BURST_LO_W-1:0] beat_addr(
      input logic [BURST_LO_W-1:0] start,
      input logic [BURST_LO_W-1:0] beat
   );
      if (BURST_ORDER == ORDER_LINEAR) begin
         beat_addr = start + beat;      // Two-bit sum wraps 11 to 00
      end else begin
         beat_addr = start ^ beat;
      end
   endfunction

   // Strobe decode; processor strobe is blocked while chip enable is high
   assign cpu_take  = ~ctl.cpu_addr_strobe_n & ~ctl.chip_enable_n;
   assign ctrl_take = ~ctl.ctrl_addr_strobe_n;
   assign load      = cpu_take | ctrl_take;
   assign advance   = ~ctl.burst_advance_n & ~load;                 // Strobe beats advance

   // Processor strobe cycles are reads, so a controller write in the same
   // cycle is dropped: only the processor strobe is recognised then
   assign wr_ok    = ~cpu_take & ~ctl.chip_enable_n;
   assign lane_wr  = {LANES{wr_ok}} & ~ctl.byte_write_n;
   assign eff_addr = load ? ext_addr : {hi_r, lo_r};

   // Next beat: restart on a strobe, step on advance, else hold
   always_comb begin
      beat_nxt = beat_r;
      lo_nxt   = lo_r;
      if (load) begin
         beat_nxt = BEAT_RST;
         lo_nxt   = ext_addr[BURST_LO_W-1:0];
      end else if (advance) begin
         beat_nxt = beat_r + BEAT_STEP;
         lo_nxt   = beat_addr(start_r, beat_r + BEAT_STEP);
      end
   end

   // Burst counter and low address
   always_ff @(posedge clk) begin
      if (rst) begin
         beat_r  <= BEAT_RST;
         lo_r    <= '0;
         start_r <= '0;
      end else begin
         beat_r <= beat_nxt;
         lo_r   <= lo_nxt;
         if (load) begin
            start_r <= ext_addr[BURST_LO_W-1:0];
         end
      end
   end

   // Upper address only changes on a strobe, never during a burst
   always_ff @(posedge clk) begin
      if (rst) begin
         hi_r <= '0;
      end else if (load) begin
         hi_r <= ext_addr[ADDR_W-1:BURST_LO_W];
      end
   end

   // Byte-lane writes; each lane carries its byte and parity bit together.
   // One array per lane, so no two processes ever write the same variable
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] lane_mem [2**ADDR_W];

         always_ff @(posedge clk) begin
            if (lane_wr[g]) begin
               lane_mem[eff_addr] <= data_in[g*LANE_W +: LANE_W];
            end
         end

         assign rd_word[g*LANE_W +: LANE_W] = lane_mem[eff_addr];
      end
   endgenerate

   // Registered read; selection follows chip enable so a deselected
   // module never drives the shared data bus
   always_ff @(posedge clk) begin
      if (rst) begin
         data_out_r <= '0;
         sel_r      <= 1'b0;
      end else begin
         data_out_r <= rd_word;          // Old word when a write hits the same cycle
         sel_r      <= ~ctl.chip_enable_n & ~(|lane_wr);
      end
   end

   assign data_out   = data_out_r;
   assign data_oe_n  = output_enable_n | ~sel_r;   // Output enable is asynchronous
   assign burst_addr = {hi_r, lo_r};

   // Presence straps are static: drive low for grounded, float for N.C.
   assign id_strap_out     = 3'h0;
   assign id_strap_oe_n[2] = (BURST_ORDER == ORDER_INTERLEAVED) ?
                             ORDER_INTL_OE_N : ORDER_LIN_OE_N;
   assign id_strap_oe_n[1:0] = (MODULE_SIZE == SIZE_256KB) ? SIZE_256KB_OE_N :
                               (MODULE_SIZE == SIZE_1MB)   ? SIZE_1MB_OE_N :
                                                             SIZE_512KB_OE_N;

   // Checks on the sequencer
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_interleave_step: assert property (
      (BURST_ORDER != ORDER_LINEAR && load) ##1 advance
      |=> lo_r == ($past(ext_addr[BURST_LO_W-1:0], 2) ^ 2'h1))
      else $error("Interleaved second beat wrong");

   chk_linear_step: assert property (
      (BURST_ORDER == ORDER_LINEAR && load) ##1 advance
      |=> lo_r == 2'($past(ext_addr[BURST_LO_W-1:0], 2) + 2'h1))
      else $error("Linear second beat wrong");

   chk_burst_wrap: assert property (
      load ##1 advance [*4] |=> lo_r == $past(ext_addr[BURST_LO_W-1:0], 5))
      else $error("Burst did not wrap after four steps");

   chk_upper_hold: assert property (
      !load |=> burst_addr[ADDR_W-1:BURST_LO_W] == $past(burst_addr[ADDR_W-1:BURST_LO_W]))
      else $error("Upper address moved during burst");

   chk_strobe_load: assert property (
      load |=> burst_addr == $past(ext_addr) && beat_r == BEAT_RST)
      else $error("Strobe did not latch address");

   chk_burst_abandon: assert property (
      load && beat_r != BEAT_RST
      |=> beat_r == BEAT_RST && lo_r == $past(ext_addr[BURST_LO_W-1:0]))
      else $error("Strobe did not abandon the burst");

   chk_both_strobe: assert property (
      cpu_take && ctrl_take |=> burst_addr == $past(ext_addr))
      else $error("Processor strobe not honoured with both strobes");

   chk_ce_blocks_cpu: assert property (
      ctl.chip_enable_n && ctl.ctrl_addr_strobe_n && ctl.burst_advance_n
      |=> $stable(burst_addr))
      else $error("Processor strobe honoured with chip enable high");

   chk_cpu_no_write: assert property (
      !ctl.cpu_addr_strobe_n && !ctl.chip_enable_n |-> lane_wr == '0)
      else $error("Write during processor strobe cycle");

   chk_advance_step: assert property (
      advance |=> beat_r == 2'($past(beat_r) + 2'h1))
      else $error("Advance did not step counter");

   chk_lane_gate: assert property (
      !ctl.chip_enable_n && ctl.cpu_addr_strobe_n |-> lane_wr == ~ctl.byte_write_n)
      else $error("Byte lane enable mismatch");

   chk_idle_hold: assert property (
      !load && ctl.burst_advance_n |=> $stable(beat_r) && $stable(lo_r))
      else $error("Counter moved while idle");

   chk_strap_order: assert property (
      id_strap_oe_n[2] == (BURST_ORDER != ORDER_INTERLEAVED))
      else $error("Burst order strap wrong");

   cov_full_burst:  cover property (load ##1 advance [*3]);
   cov_both_strobe: cover property (cpu_take && ctrl_take);
   cov_abandon:     cover property (load ##1 advance ##1 load);
   cov_lane_write:  cover property (ctrl_take && lane_wr != '0);
   cov_burst_wrap:  cover property (load ##1 advance [*4]);

endmodule

// ===== tb/host_bus_model.sv
// Purpose: Host bus model turning bench commands into strobe, advance and address pins
// Assumes: Command changes just after a rising clock edge
// Notes:   Released address shows its inverse so a stale value cannot pass
`timescale 1ns/10ps
module host_bus_model
   import burst_sram_pkg::*;
(
   input  wire logic [2:0]  kind,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wr_n,
   output logic [15:0]      ext_addr,
   output bus_ctl_t         ctl
);
   // Kinds: 0 idle, 1 advance, 2 ctrl load, 3 cpu load, 4 both, 5 cpu with chip off
   always_comb begin
      ctl.cpu_addr_strobe_n  = !(kind inside {3'h3, 3'h4, 3'h5});
      ctl.ctrl_addr_strobe_n = !(kind inside {3'h2, 3'h4});
      ctl.burst_advance_n    = !(kind inside {3'h1, 3'h2}); // Load with advance
      ctl.chip_enable_n      = (kind == 3'h5); // Blocks the cpu strobe
      ctl.byte_write_n       = wr_n;
      ext_addr = (kind inside {3'h2, 3'h3, 3'h4, 3'h5}) ? addr : ~addr;
   end
endmodule

// ===== tb/burst_sram_address_sequencer_test.sv
// Purpose: Self-checking bench for burst address sequencing and straps
// Assumes: One interleaved 256KB and one linear 1MB build share one bus
// Notes:   A lane-wise memory model mirrors the writes, so read data is compared too
`timescale 1ns/10ps
module burst_sram_address_sequencer_test;
   import burst_sram_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  kind = 3'h0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wr_n = 8'hff;
   logic [71:0] wdata = 72'h0;
   logic [15:0] ext_addr, ba_i, ba_l;
   logic [2:0]  oe_i, oe_l, so_i, so_l;
   bus_ctl_t    ctl;
   logic [71:0] dout_i, dout_l;
   logic        drv_i_n, drv_l_n;
   logic [177:0] exp_q[$];
   logic [177:0] note;
   logic [71:0] mem_i [65536];
   logic [71:0] mem_l [65536];
   logic [13:0] hi = 14'h0000;
   logic [1:0]  st = 2'h0;
   logic [1:0]  bt = 2'h0;
   int          err_total = 0;
   int          total_checks = 0;
   int          seed = 17;
   int          cycles = 0;

   host_bus_model host (.kind(kind), .addr(addr), .wr_n(wr_n), .ext_addr(ext_addr), .ctl(ctl));
   burst_sram_address_sequencer #(.BURST_ORDER(ORDER_INTERLEAVED), .MODULE_SIZE(SIZE_256KB))
      dut (.clk(clk), .rst(rst), .ext_addr(ext_addr), .ctl(ctl), .output_enable_n(1'b0),
      .data_in(wdata), .data_out(dout_i), .data_oe_n(drv_i_n), .burst_addr(ba_i),
      .id_strap_out(so_i), .id_strap_oe_n(oe_i));
   burst_sram_address_sequencer #(.BURST_ORDER(ORDER_LINEAR), .MODULE_SIZE(SIZE_1MB))
      dut_lin (.clk(clk), .rst(rst), .ext_addr(ext_addr), .ctl(ctl), .output_enable_n(1'b0),
      .data_in(wdata), .data_out(dout_l), .data_oe_n(drv_l_n), .burst_addr(ba_l),
      .id_strap_out(so_l), .id_strap_oe_n(oe_l));

   // Free-running 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [143:0] got, input logic [143:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("errors %0d checks %0d", err_total, total_checks);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One command per clock; the note is queued once the sampling edge has passed
   task automatic step(input logic [2:0] k);
      logic [15:0] a;
      logic [7:0]  w;
      logic [71:0] d;
      logic [15:0] ea_i;
      logic [15:0] ea_l;
      logic [71:0] rd_i;
      logic [71:0] rd_l;
      logic        sel;
      a = 16'($random(seed));
      w = 8'($random(seed));
      d = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      kind <= k;
      addr <= a;
      wr_n <= w;
      wdata <= d;
      // Word read this cycle: the new address on a strobe, else the current beat
      ea_i = (k inside {3'h2, 3'h3, 3'h4}) ? a : {hi, st ^ bt};
      ea_l = (k inside {3'h2, 3'h3, 3'h4}) ? a : {hi, 2'(st + bt)};
      rd_i = mem_i[ea_i];
      rd_l = mem_l[ea_l];
      // Writes need chip enable and are dropped in processor strobe cycles
      sel = (k != 3'h5) && ((k inside {3'h3, 3'h4}) || w == 8'hff);
      if (!(k inside {3'h3, 3'h4, 3'h5})) begin
         for (int g = 0; g < 8; g++) begin
            if (!w[g]) begin
               mem_i[ea_i][g*9 +: 9] = d[g*9 +: 9];
               mem_l[ea_l][g*9 +: 9] = d[g*9 +: 9];
            end
         end
      end
      if (k inside {3'h2, 3'h3, 3'h4}) begin
         hi = a[15:2];
         st = a[1:0];
         bt = 2'h0;
      end else if (k == 3'h1) begin
         bt = bt + 2'h1;
      end
      @(posedge clk);
      exp_q.push_back({hi, st ^ bt, hi, 2'(st + bt), rd_i, rd_l, ~sel, ~sel});
   endtask

   // Settled outputs are compared at the falling edge against the oldest note
   always @(negedge clk) begin
      if (exp_q.size() > 0) begin
         note = exp_q.pop_front();
         check({ba_i, ba_l}, note[177:146]);
         check({dout_i, dout_l}, note[145:2]);
         check({drv_i_n, drv_l_n}, note[1:0]);
      end
   end

   // Hang guard: the run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         finish_test();
      end
   end

   // Bursts of one to four advance steps, so later loads abandon bursts midway
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      check({oe_i, oe_l, so_i, so_l}, {20'h0_0000, 3'h1, 3'h6, 6'h00});
      for (int n = 0; n < 48; n++) begin
         step(3'(2 + n % 3));
         repeat (1 + n % 4) step(3'h1);
         // Odd rounds idle and deselect; even rounds are cut by the next strobe
         if (n % 2 == 1) begin
            step(3'h0);
            step(3'h5);
         end
      end
      repeat (2) step(3'h0);
      // Let the watcher compare the last note before the verdict
      @(negedge clk);
      @(posedge clk);
      finish_test();
   end
endmodule
